// File: src/fspc_ctrl.sv
`timescale 1ns/100ps
// Function
// - Flash is programmed page-wise from the buffer; erase precedes write.
// - Buffer words may be written in any order within the page.
// - Command 00000011 plus store within four clocks erases the indexed page.
// - Core is halted for the whole page erase.
// - Command 00000001 plus store loads the data word at the word index.
// - Buffer clears after page write, on buffer-clear command, and on reset.
// - EEPROM write during page loading discards the buffer contents.
// - Command 00000101 plus store programs the indexed page from the buffer.
// - Core is halted for the whole page write.
// - Store instruction is accepted from any flash location.
// - Load instruction uses pointer bit 0 as byte select.
// - EEPROM write in progress blocks programming commands and fuse reads.
// - Pointer 0x0001 fuse read returns two lock bits in bits 1:0.
// - Pointers 0x0000, 0x0003, 0x0002 return fuse low, high, extended bytes.
// - Fuse-read and enable bits clear on read, three-cycle or four-cycle timeout.
// - Programmed fuse and lock bits read as 0, unprogrammed as 1.
// - A flash write running at reset completes rather than aborts.
// - Page erase or write lasts between 3.7 ms and 4.5 ms.
// - Low five control bits other than five commands have no effect.
// - Enable bit stays set during erase or write unless reset clears it; clears at completion.
// - Enable arms store for four clocks; bits clear after store or timeout.
module fspc_ctrl #(
	parameter int PAGE_WORDS = 32,
	parameter int PAGES = 64,
	parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES
) (
	input wire logic CORE_CLK, // Core clock, 125 MHz
	input wire logic RST_B, // Asynchronous reset, active low
	input wire logic [3:0] REG_ADDR, // Register address
	input wire logic [7:0] REG_WDATA, // Register write data
	input wire logic REG_WR, // Register write strobe
	input wire logic REG_RD, // Register read strobe
	output logic [7:0] REG_RDATA, // Read data, cycle after strobe
	input wire logic STORE_STROBE, // Store-program instruction issued
	input wire logic LOAD_STROBE, // Load-program instruction issued
	output logic LOAD_HIT, // Load answered by fuse/lock data
	output logic [7:0] LOAD_DATA, // Fuse/lock byte for the load
	input wire logic EEPROM_WRITE_BUSY, // EEPROM write in progress
	input wire logic [7:0] FUSE_LOW_BYTE, // Fuse low byte, 0 = programmed
	input wire logic [7:0] FUSE_HIGH_BYTE, // Fuse high byte
	input wire logic [7:0] FUSE_EXTENDED_BYTE, // Extended fuse byte
	input wire logic LOCK_BIT_HI, // Lock bit 2
	input wire logic LOCK_BIT_LO, // Lock bit 1
	output logic CORE_HALT, // Halts the core
	output logic FLASH_ERASE, // Page erase pulse
	output logic FLASH_WRITE, // Page write pulse
	output logic [15:0] FLASH_PAGE, // Target page index
	output logic [15:0] FLASH_WDATA, // Word written to flash
	output logic [15:0] FLASH_WADDR, // Word index within page for FLASH_WDATA
	output logic FLASH_WSTROBE // One word of page written to flash
);
	localparam int WB = $clog2(PAGE_WORDS);
	localparam int PB = $clog2(PAGES);
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

	typedef struct packed {
		fspc_pkg::fspc_state_t state;
		logic [7:0] ctrl;
		logic [2:0] win;
		logic [15:0] ptr;
		logic [15:0] data;
		logic [CW-1:0] cnt;
		logic [WB-1:0] copy_idx;
		logic [PB-1:0] page;
		logic [7:0] rdata;
		logic load_hit;
		logic [7:0] load_data;
		logic erase_p;
		logic write_p;
		logic wstrobe;
		logic [15:0] wdata;
		logic [WB-1:0] waddr;
		logic [PAGE_WORDS-1:0] valid;
	} fspc_regs_t;

	fspc_regs_t r, next_r;
	logic [15:0] buf_mem [PAGE_WORDS];
	logic ee_meta, ee_busy;
	logic [7:0] fl_meta, fh_meta, fe_meta, fl_s, fh_s, fe_s;
	logic [1:0] lk_meta, lk_s;

	// Picks the fuse/lock byte for a pointer; strap levels pass through as read
	function automatic logic [7:0] fspc_fuse_sel(input logic [15:0] p, input logic [7:0] fl,
		input logic [7:0] fh, input logic [7:0] fe, input logic [1:0] lk);
		logic [7:0] v;
		v = 8'hff;
		case (p)
			fspc_pkg::PTR_LOCK: v = {6'h3f, lk};
			fspc_pkg::PTR_FUSE_LOW: v = fl;
			fspc_pkg::PTR_FUSE_HIGH: v = fh;
			fspc_pkg::PTR_FUSE_EXT: v = fe;
			default: v = 8'hff;
		endcase
		return v;
	endfunction

	// Only these five low-bit patterns are commands; anything else is dropped
	function automatic logic fspc_cmd_known(input logic [4:0] c);
		logic k;
		k = 1'b0;
		case (c)
			fspc_pkg::CMD_LOAD, fspc_pkg::CMD_ERASE, fspc_pkg::CMD_WRITE: k = 1'b1;
			fspc_pkg::CMD_FUSE, fspc_pkg::CMD_CLEAR: k = 1'b1;
			default: k = 1'b0;
		endcase
		return k;
	endfunction

	// Register read decode; unmapped offsets read as zero
	function automatic logic [7:0] fspc_reg_read(input logic [3:0] a, input logic [7:0] c,
		input logic [15:0] p, input logic [15:0] d);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			fspc_pkg::OFS_CTRL: v = {3'h0, c[4:0]};
			fspc_pkg::OFS_PTR_LO: v = p[7:0];
			fspc_pkg::OFS_PTR_HI: v = p[15:8];
			fspc_pkg::OFS_DATA_LO: v = d[7:0];
			fspc_pkg::OFS_DATA_HI: v = d[15:8];
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Page and word fields of the pointer; bit 0 is the byte select
	function automatic logic [PB-1:0] fspc_page_of(input logic [15:0] p);
		return p[WB+PB:WB+1];
	endfunction
	function automatic logic [WB-1:0] fspc_word_of(input logic [15:0] p);
		return p[WB:1];
	endfunction

	// Asynchronous inputs pass two flops
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ee_meta <= 1'b0;
			ee_busy <= 1'b0;
			fl_meta <= 8'hff;
			fl_s <= 8'hff;
			fh_meta <= 8'hff;
			fh_s <= 8'hff;
			fe_meta <= 8'hff;
			fe_s <= 8'hff;
			lk_meta <= 2'h3;
			lk_s <= 2'h3;
		end else begin
			ee_meta <= EEPROM_WRITE_BUSY;
			ee_busy <= ee_meta;
			fl_meta <= FUSE_LOW_BYTE;
			fl_s <= fl_meta;
			fh_meta <= FUSE_HIGH_BYTE;
			fh_s <= fh_meta;
			fe_meta <= FUSE_EXTENDED_BYTE;
			fe_s <= fe_meta;
			lk_meta <= {LOCK_BIT_HI, LOCK_BIT_LO};
			lk_s <= lk_meta;
		end
	end

	logic [4:0] cmd;
	logic armed;
	logic do_store;
	logic fuse_mode;
	assign cmd = r.ctrl[4:0];
	assign armed = r.ctrl[fspc_pkg::CTL_ENABLE] && r.state == fspc_pkg::FSPC_IDLE && fspc_cmd_known(cmd);
	assign fuse_mode = armed && cmd == fspc_pkg::CMD_FUSE;
	// A store with nothing armed falls through untouched
	assign do_store = STORE_STROBE && armed;

	// Helper terms for the sequencer below
	logic ctrl_wr;
	logic ptr_wr;
	logic fuse_expire;
	logic copy_active;
	logic op_last;
	assign ctrl_wr = REG_WR && REG_ADDR == fspc_pkg::OFS_CTRL && !r.ctrl[fspc_pkg::CTL_ENABLE]
		&& !ee_busy && fspc_cmd_known(REG_WDATA[4:0]);
	assign ptr_wr = REG_WR && r.state == fspc_pkg::FSPC_IDLE;
	// The load window is one cycle shorter than the store window
	assign fuse_expire = fuse_mode && (fspc_pkg::STORE_WINDOW - r.win) >= (fspc_pkg::LOAD_WINDOW - 3'h1);
	// Words go out in the first PAGE_WORDS cycles of a write; the rest is programming time
	assign copy_active = r.state == fspc_pkg::FSPC_WRITE && r.cnt < CW'(PAGE_WORDS);
	assign op_last = r.cnt == PROG_LAST;

	// One-hot word decode, any word in any order
	logic [PAGE_WORDS-1:0] word_sel;
	genvar gi;
	generate
		for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_word
			assign word_sel[gi] = fspc_word_of(r.ptr) == WB'(gi);
		end
	endgenerate

	always_comb begin
		next_r = r;
		next_r.erase_p = 1'b0;
		next_r.write_p = 1'b0;
		next_r.wstrobe = 1'b0;
		next_r.load_hit = 1'b0;
		next_r.rdata = 8'h00;
		if (REG_RD) begin
			next_r.rdata = fspc_reg_read(REG_ADDR, r.ctrl, r.ptr, r.data);
		end

		// Later assignments take priority: a load answer beats the fuse timeout
		case (r.state)
			fspc_pkg::FSPC_IDLE: begin
				if (r.ctrl[fspc_pkg::CTL_ENABLE]) begin
					next_r.win = r.win - 3'h1;
					if (r.win == 3'h1) begin
						next_r.ctrl = fspc_pkg::CTL_RESET;
					end
				end
				if (fuse_expire) begin
					next_r.ctrl = fspc_pkg::CTL_RESET;
				end
				if (fuse_mode && LOAD_STROBE) begin
					next_r.load_hit = 1'b1;
					next_r.load_data = fspc_fuse_sel(r.ptr, fl_s, fh_s, fe_s, lk_s);
					next_r.ctrl = fspc_pkg::CTL_RESET;
				end
				if (do_store) begin
					next_r.ctrl = fspc_pkg::CTL_RESET;
					case (cmd)
						fspc_pkg::CMD_LOAD: begin
							next_r.valid = r.valid | word_sel;
						end
						fspc_pkg::CMD_ERASE: begin
							next_r.page = fspc_page_of(r.ptr);
							next_r.state = fspc_pkg::FSPC_ERASE;
							next_r.ctrl = r.ctrl;
							next_r.erase_p = 1'b1;
							next_r.cnt = '0;
						end
						fspc_pkg::CMD_WRITE: begin
							next_r.page = fspc_page_of(r.ptr);
							next_r.state = fspc_pkg::FSPC_WRITE;
							next_r.ctrl = r.ctrl;
							next_r.write_p = 1'b1;
							next_r.cnt = '0;
							next_r.copy_idx = '0;
						end
						default: next_r.ctrl = fspc_pkg::CTL_RESET;
					endcase
				end
				if (ctrl_wr) begin
					case (REG_WDATA[4:0])
						fspc_pkg::CMD_LOAD, fspc_pkg::CMD_ERASE, fspc_pkg::CMD_WRITE, fspc_pkg::CMD_FUSE: begin
							next_r.ctrl = {3'h0, REG_WDATA[4:0]};
							next_r.win = fspc_pkg::STORE_WINDOW;
						end
						fspc_pkg::CMD_CLEAR: begin
							next_r.valid = '0;
						end
						default: next_r.ctrl = r.ctrl;
					endcase
				end
			end
			// Erase and write share the timer; only a write streams words out
			fspc_pkg::FSPC_ERASE, fspc_pkg::FSPC_WRITE: begin
				next_r.cnt = r.cnt + CW'(1);
				if (copy_active) begin
					next_r.wstrobe = 1'b1;
					next_r.waddr = r.copy_idx;
					// Unloaded words stay erased
					next_r.wdata = r.valid[r.copy_idx] ? buf_mem[r.copy_idx] : 16'hffff;
					next_r.copy_idx = r.copy_idx + WB'(1);
				end
				if (op_last) begin
					next_r.state = fspc_pkg::FSPC_IDLE;
					next_r.ctrl = fspc_pkg::CTL_RESET;
					if (r.state == fspc_pkg::FSPC_WRITE) begin
						next_r.valid = '0;
					end
				end
			end
			default: next_r.state = fspc_pkg::FSPC_IDLE;
		endcase

		// Clearing beats a word loaded in the same cycle: that load sequence is void anyway
		if (ee_busy && r.state == fspc_pkg::FSPC_IDLE) begin
			next_r.valid = '0;
		end

		if (ptr_wr) begin
			case (REG_ADDR)
				fspc_pkg::OFS_PTR_LO: next_r.ptr[7:0] = REG_WDATA;
				fspc_pkg::OFS_PTR_HI: next_r.ptr[15:8] = REG_WDATA;
				fspc_pkg::OFS_DATA_LO: next_r.data[7:0] = REG_WDATA;
				fspc_pkg::OFS_DATA_HI: next_r.data[15:8] = REG_WDATA;
				default: next_r.ptr = r.ptr;
			endcase
		end
	end

	// Buffer words; validity flags give the clear-all behaviour without wiping the array
	always_ff @(posedge CORE_CLK) begin
		if (do_store && cmd == fspc_pkg::CMD_LOAD) begin
			buf_mem[fspc_word_of(r.ptr)] <= r.data;
		end
	end

	// Reset leaves a running erase or write alone so that it completes; the operation only
	// pauses while reset is held. An unknown power-up state falls to the default branch.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			r.ctrl <= fspc_pkg::CTL_RESET;
			r.win <= '0;
			r.ptr <= '0;
			r.data <= '0;
			r.rdata <= '0;
			r.load_hit <= 1'b0;
			r.load_data <= 8'hff;
			r.valid <= '0;
			case (r.state)
				fspc_pkg::FSPC_ERASE, fspc_pkg::FSPC_WRITE: begin
					// Start pulses must not repeat; word strobe and timer just hold
					r.erase_p <= 1'b0;
					r.write_p <= 1'b0;
				end
				default: begin
					r.state <= fspc_pkg::FSPC_IDLE;
					r.cnt <= '0;
					r.copy_idx <= '0;
					r.page <= '0;
					r.erase_p <= 1'b0;
					r.write_p <= 1'b0;
					r.wstrobe <= 1'b0;
					r.wdata <= '0;
					r.waddr <= '0;
				end
			endcase
		end else begin
			r.state <= next_r.state;
			r.ctrl <= next_r.ctrl;
			r.win <= next_r.win;
			r.ptr <= next_r.ptr;
			r.data <= next_r.data;
			r.cnt <= next_r.cnt;
			r.copy_idx <= next_r.copy_idx;
			r.page <= next_r.page;
			r.rdata <= next_r.rdata;
			r.load_hit <= next_r.load_hit;
			r.load_data <= next_r.load_data;
			r.erase_p <= next_r.erase_p;
			r.write_p <= next_r.write_p;
			r.wstrobe <= next_r.wstrobe;
			r.wdata <= next_r.wdata;
			r.waddr <= next_r.waddr;
			r.valid <= next_r.valid;
		end
	end

	assign CORE_HALT = r.state != fspc_pkg::FSPC_IDLE;
	assign REG_RDATA = r.rdata;
	assign LOAD_HIT = r.load_hit;
	assign LOAD_DATA = r.load_data;
	assign FLASH_ERASE = r.erase_p;
	assign FLASH_WRITE = r.write_p;
	assign FLASH_PAGE = 16'(r.page);
	assign FLASH_WDATA = r.wdata;
	assign FLASH_WADDR = 16'(r.waddr);
	assign FLASH_WSTROBE = r.wstrobe;
endmodule

// File: src/fspc_pkg.sv
package fspc_pkg;
	// Control register fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_ERASE = 1;
	localparam int CTL_WRITE = 2;
	localparam int CTL_FUSE = 3;
	localparam int CTL_CLEAR = 4;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_FUSE = 5'h09;
	localparam logic [4:0] CMD_CLEAR = 5'h11;
	// Register offsets on the plain port
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_PTR_LO = 4'h1;
	localparam logic [3:0] OFS_PTR_HI = 4'h2;
	localparam logic [3:0] OFS_DATA_LO = 4'h3;
	localparam logic [3:0] OFS_DATA_HI = 4'h4;
	// Fuse/lock read pointers
	localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
	localparam logic [15:0] PTR_LOCK = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
	// Arming windows in core clocks
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW = 3'h3;
	// Programming time
	localparam int CLK_MHZ = 125;
	localparam int PROG_MIN_US = 3700;
	localparam int PROG_MAX_US = 4500;
	localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
	typedef enum logic [1:0] {FSPC_IDLE, FSPC_ERASE, FSPC_WRITE} fspc_state_t;
endpackage

// File: verification/fspc_ctrl_props.sv
`timescale 1ns/100ps
module fspc_ctrl_props #(
	parameter int PROG_CYCLES = 64
) (
	input wire logic CORE_CLK, // Core clock
	input wire logic RST_B, // Reset, active low
	input wire logic STORE_STROBE, // Store instruction
	input wire logic LOAD_STROBE, // Load instruction
	input wire logic LOAD_HIT, // Fuse read answer
	input wire logic EEPROM_WRITE_BUSY, // EEPROM busy
	input wire logic CORE_HALT, // Core halt
	input wire logic FLASH_ERASE, // Erase pulse
	input wire logic FLASH_WRITE, // Write pulse
	input wire logic [15:0] FLASH_PAGE, // Page index
	input wire logic FLASH_WSTROBE // Word strobe
);
	int halt_cnt = 0;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	// Not reset on purpose: a running operation outlives reset, pausing while reset is held
	always_ff @(posedge CORE_CLK) begin
		halt_cnt <= CORE_HALT ? halt_cnt + (RST_B ? 1 : 0) : 0;
	end
	halt_len_a: assert property ($fell(CORE_HALT) |-> halt_cnt == PROG_CYCLES)
		else $error("halt length wrong");
	op_start_a: assert property ($rose(CORE_HALT) |-> $past(STORE_STROBE) && (FLASH_ERASE ^ FLASH_WRITE))
		else $error("operation start wrong");
	op_pulse_a: assert property ((FLASH_ERASE || FLASH_WRITE) |=> !(FLASH_ERASE || FLASH_WRITE) && CORE_HALT)
		else $error("operation pulse wrong");
	word_in_op_a: assert property (FLASH_WSTROBE |-> CORE_HALT && !FLASH_ERASE)
		else $error("word strobe outside write");
	page_hold_a: assert property (CORE_HALT && $past(CORE_HALT) && $past(RST_B) |-> $stable(FLASH_PAGE))
		else $error("page index moved");
	hit_cause_a: assert property (LOAD_HIT |-> $past(LOAD_STROBE))
		else $error("load answer without load");
	one_read_a: assert property (LOAD_HIT ##1 LOAD_STROBE |=> !LOAD_HIT)
		else $error("fuse read not cleared");
	ee_block_a: assert property (EEPROM_WRITE_BUSY [*8] |=> !$rose(CORE_HALT))
		else $error("operation during EEPROM write");
endmodule
bind fspc_ctrl fspc_ctrl_props #(.PROG_CYCLES(PROG_CYCLES)) fspc_ctrl_props_inst (.*);

// File: verification/fspc_flash_model.sv
`timescale 1ns/100ps
module fspc_flash_model (
	input wire logic clk, // Core clock
	input wire logic erase, // Page erase pulse
	input wire logic write, // Page write pulse
	input wire logic [15:0] page, // Target page
	input wire logic [15:0] waddr, // Word index
	input wire logic [15:0] wdata, // Word data
	input wire logic wstrobe // Word strobe
);
	logic [15:0] mem [0:63][0:31];
	int n_wr = 0;
	int nws = 0;
	always @(posedge clk) begin
		if (erase) begin
			for (int i = 0; i < 32; i++) mem[page[5:0]][i] = 16'hffff;
		end
		if (write) begin
			n_wr++;
			nws = 0;
		end
		// Programming only clears bits, so an unerased page keeps stale zeros
		if (wstrobe) begin
			mem[page[5:0]][waddr[4:0]] &= wdata;
			nws++;
		end
	end
endmodule

// File: verification/fspc_ctrl_tb.sv
`timescale 1ns/100ps
module fspc_ctrl_tb;
	localparam int PC = 64;
	logic clk, rst_b, wr, rd, store, load, ee, lhi, llo, hit, halt, fer, fwr, fws;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, ldata, fl, fh, fe;
	logic [15:0] fpage, fwd, fwa, v;
	logic [15:0] eb [0:31];
	logic [15:0] q [$];
	logic [5:0] pg;
	logic rdp = 0;
	logic [31:0] seed = 33974;
	int n_fail = 0;
	int check_count = 0;
	int nh = 0;
	fspc_ctrl #(.PROG_CYCLES(PC)) fspc_ctrl_inst (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .STORE_STROBE(store),
		.LOAD_STROBE(load), .LOAD_HIT(hit), .LOAD_DATA(ldata), .EEPROM_WRITE_BUSY(ee),
		.FUSE_LOW_BYTE(fl), .FUSE_HIGH_BYTE(fh), .FUSE_EXTENDED_BYTE(fe), .LOCK_BIT_HI(lhi),
		.LOCK_BIT_LO(llo), .CORE_HALT(halt), .FLASH_ERASE(fer), .FLASH_WRITE(fwr), .FLASH_PAGE(fpage),
		.FLASH_WDATA(fwd), .FLASH_WADDR(fwa), .FLASH_WSTROBE(fws));
	fspc_flash_model fspc_flash_model_inst (.clk(clk), .erase(fer), .write(fwr), .page(fpage),
		.waddr(fwa), .wdata(fwd), .wstrobe(fws));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		q.push_back({8'hff, e});
		@(posedge clk);
		rd <= 0;
	endtask
	task automatic ptr(logic [15:0] p);
		wreg(4'h1, p[7:0]);
		wreg(4'h2, p[15:8]);
	endtask
	task automatic spm(logic [7:0] c);
		wreg(4'h0, c);
		store <= 1;
		@(posedge clk);
		store <= 0;
	endtask
	task automatic ld(int w);
		eb[w] = rnd();
		ptr(16'(w * 2));
		wreg(4'h3, eb[w][7:0]);
		wreg(4'h4, eb[w][15:8]);
		spm(8'h01);
	endtask
	task automatic clr();
		foreach (eb[i]) eb[i] = 16'hffff;
	endtask
	task automatic op(logic [7:0] c);
		ptr({4'h0, pg, 6'h0});
		spm(c);
		rreg(4'h0, c);
		chk("page", fpage, {10'h0, pg});
		cyc(PC);
	endtask
	task automatic fuse(logic [15:0] p, logic [7:0] m, logic [7:0] e);
		ptr(p);
		wreg(4'h0, 8'h09);
		load <= 1;
		q.push_back({m, e & m});
		@(posedge clk);
		load <= 0;
		@(posedge clk);
		load <= 1;
		@(posedge clk);
		load <= 0;
		rreg(4'h0, 8'h00);
	endtask
	always @(posedge clk) begin
		rdp <= rd;
		if (rdp) begin
			v = q.pop_front();
			chk("rdata", {8'h0, rdata & v[15:8]}, {8'h0, v[7:0]});
		end
		if (hit) begin
			nh++;
			v = q.pop_front();
			chk("load", {8'h0, ldata & v[15:8]}, {8'h0, v[7:0]});
		end
		if (fws) chk("word", fwd, eb[fwa[4:0]]);
	end
	initial begin
		cyc(3000);
		n_fail++;
		stop_test();
	end
	initial begin
		rst_b = 0;
		{wr, rd, store, load, ee} = 5'h00;
		addr = 4'h0;
		wdata = 8'h00;
		{fl, fh} = rnd();
		fe = 8'(rnd());
		{lhi, llo} = 2'(rnd());
		pg = 6'(rnd());
		clr();
		cyc(20);
		rst_b <= 1;
		rreg(4'h0, 8'h00);
		rreg(4'h7, 8'h00);
		for (int k = 0; k < 6; k++) ld((k * 7 + 3) % 32);
		op(8'h03);
		op(8'h05);
		chk("words", 16'(fspc_flash_model_inst.nws), 16'd32);
		clr();
		op(8'h05);
		ld(9);
		wreg(4'h0, 8'h11);
		clr();
		op(8'h05);
		ld(5);
		ee <= 1;
		cyc(3);
		spm(8'h05);
		cyc(8);
		ee <= 0;
		clr();
		cyc(3);
		chk("writes", 16'(fspc_flash_model_inst.n_wr), 16'd3);
		op(8'h05);
		spm(8'h07);
		rreg(4'h0, 8'h00);
		wreg(4'h0, 8'h05);
		cyc(5);
		rreg(4'h0, 8'h00);
		spm(8'h00);
		chk("writes", 16'(fspc_flash_model_inst.n_wr), 16'd4);
		fuse(16'h0000, 8'hff, fl);
		fuse(16'h0001, 8'h03, {6'h0, lhi, llo});
		fuse(16'h0002, 8'hff, fe);
		fuse(16'h0003, 8'hff, fh);
		chk("hits", 16'(nh), 16'd4);
		ptr({4'h0, pg, 6'h0});
		spm(8'h05);
		cyc(10);
		rst_b <= 0;
		cyc(2);
		rst_b <= 1;
		cyc(2);
		chk("halt", {15'h0, halt}, 16'h1);
		cyc(PC);
		chk("writes", 16'(fspc_flash_model_inst.n_wr), 16'd5);
		stop_test();
	end
endmodule
